// *** adcs_pkg.sv ***
// constants, types and carriers for the converter bus slave
// assumes one system clock and the bus clock as the link domain
// Contract
// - continuous mode stores each result and restarts conversion at once.
// - single mode idles until started, converts once, clears flag, powers down.
// - a start written during a running conversion is ignored, never queued.
// - continuous to single finishes the conversion, clears flag, powers down.
// - power-up reset loads every configuration bit with its default.
// - general-call reset reloads configuration, result and sequencer as a power-on reset does.
// - device is slave only; bus clock is input, never driven.
// - bus lines are only pulled low or released, never driven high.
// - eight-bit groups; data changes while clock low, sampled on clock high.
// - data falling with clock high is start; rising is stop.
// - after start, seven address bits plus direction; answer only on match.
// - receiver acknowledges by holding data low during the ninth clock.
// - data left high during acknowledge clock means not-acknowledge.
// - stop returns bus idle; start while active is a repeated start.
// - two three-level pins select eight addresses; float/float is invalid.
// - address pins sampled at power-up and after a general call.
// - general-call address with write direction is acknowledged; next byte commands.
// - command 04h re-latches the address pins without reset.
// - command 06h re-latches the address pins and resets registers.
// - read returns result high, result low, then configuration byte.
// - write stores and acknowledges only the first data byte.
// - high-speed master code is not acknowledged; mode ends at stop.
// - flag clears when result stored, sets after configuration byte read.
package adcs_pkg;

  typedef struct packed {
    logic floating;
    logic high;
  } adcs_pin_t;

  typedef struct packed {
    logic ready;
    logic [1:0] mux;
    logic single;
    logic [1:0] rate;
    logic [1:0] gain;
  } adcs_cfg_t;

  typedef struct packed {
    logic gc_reset;
    logic gc_latch;
    logic cfg_read;
    logic cfg_write;
  } adcs_evt_t;

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_WR, L_RD, L_GC, L_IGN}
    adcs_link_t;
  typedef enum logic {S_IDLE, S_CONV} adcs_seq_t;

  localparam logic [7:0] CFG_DEFAULT = 8'h8c;
  localparam logic [15:0] RESULT_DEFAULT = 16'h0000;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_CMD_LATCH = 8'h04;
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] ADDR_BASE = 4'h9;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] RD_IDX_CFG = 2'h2;
  localparam logic [1:0] RD_IDX_FILL = 2'h3;
  localparam logic [1:0] PIN_SETTLE = 2'h2;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  localparam int CONV_CYCLES_DEFAULT = 1000;
  localparam int CONV_CYCLES_MAX = 65535;

endpackage

// *** adcs_slave.sv ***
// bus slave, configuration and conversion sequencing of the converter
// assumes open-drain wire resolved outside; scl is the link clock
`timescale 1ns/1ns
module adcs_slave #(
  parameter int CONV_CYCLES = adcs_pkg::CONV_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire adcs_pkg::adcs_pin_t addr_sel_pin_low,
  input wire adcs_pkg::adcs_pin_t addr_sel_pin_high,
  input wire logic [15:0] core_result,
  output logic core_power_on,
  output logic [1:0] core_mux,
  output logic [1:0] core_rate,
  output logic [1:0] core_gain,
  output logic hs_mode_active
);

  generate
    if (CONV_CYCLES < 2 || CONV_CYCLES > adcs_pkg::CONV_CYCLES_MAX) begin : g_bad
      $error("CONV_CYCLES out of range");
    end
  endgenerate

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // link side
  logic start_tgl_reg;
  logic stop_snap_reg;
  logic hs_tgl_reg;
  logic hs_ack_reg;
  logic start_seen_reg;
  adcs_pkg::adcs_link_t link_st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] tx_reg;
  logic [7:0] wr_data_reg;
  adcs_pkg::adcs_evt_t evt_tgl_reg;
  logic sda_oe_reg;
  logic [7:0] byte_w;
  logic link_busy;

  // system side
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] addr_pins_reg;
  logic busy_s1_reg;
  logic busy_s2_reg;
  adcs_pkg::adcs_evt_t evt_s1_reg;
  adcs_pkg::adcs_evt_t evt_s2_reg;
  adcs_pkg::adcs_evt_t evt_s3_reg;
  adcs_pkg::adcs_evt_t evt_pulse;
  logic [1:0] startup_cnt_reg;
  adcs_pkg::adcs_cfg_t cfg_reg;
  adcs_pkg::adcs_cfg_t wr_cfg;
  adcs_pkg::adcs_cfg_t shadow_cfg_reg;
  logic [15:0] result_reg;
  logic [15:0] shadow_result_reg;
  adcs_pkg::adcs_seq_t seq_reg;
  logic [15:0] conv_cnt_reg;
  logic conv_done;
  logic start_accept;
  logic int_rst;
  logic [3:0] addr_map;
  logic [6:0] dev_addr;
  logic addr_valid;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] pin_level(input adcs_pkg::adcs_pin_t p);
    if (p.floating) begin
      return adcs_pkg::LVL_FLOAT;
    end
    return p.high ? adcs_pkg::LVL_HIGH : adcs_pkg::LVL_LOW;
  endfunction

  // {valid, low three address bits} from {high pin, low pin} levels
  function automatic logic [3:0] map_addr(input logic [3:0] lv);
    case (lv)
      4'h0: return 4'h8;
      4'h2: return 4'h9;
      4'h1: return 4'ha;
      4'h4: return 4'hc;
      4'h6: return 4'hd;
      4'h5: return 4'he;
      4'h8: return 4'hb;
      4'h9: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(
    input logic [1:0] idx,
    input logic [15:0] res,
    input adcs_pkg::adcs_cfg_t c
  );
    case (idx)
      2'h0: return res[15:8];
      2'h1: return res[7:0];
      2'h2: return c;
      default: return adcs_pkg::READ_FILL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // start and stop detection on data edges

  always_ff @(negedge sda_in or negedge resetn) begin
    if (!resetn) begin
      start_tgl_reg <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_ff @(posedge sda_in or negedge resetn) begin
    if (!resetn) begin
      stop_snap_reg <= 1'b0;
      hs_ack_reg <= 1'b0;
    end else if (scl_clk) begin
      stop_snap_reg <= start_tgl_reg;
      hs_ack_reg <= hs_tgl_reg;
    end
  end

  assign link_busy = start_tgl_reg ^ stop_snap_reg;
  assign hs_mode_active = hs_tgl_reg ^ hs_ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link state machine, sampled on clock rise

  assign byte_w = {shift_reg[6:0], sda_in};

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      start_seen_reg <= 1'b0;
      link_st_reg <= adcs_pkg::L_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
      tx_reg <= 8'h00;
      wr_data_reg <= adcs_pkg::CFG_DEFAULT;
      evt_tgl_reg <= '0;
      hs_tgl_reg <= 1'b0;
    end else if (start_seen_reg != start_tgl_reg) begin
      start_seen_reg <= start_tgl_reg;
      link_st_reg <= adcs_pkg::L_ADDR;
      bit_cnt_reg <= 4'h1;
      shift_reg <= {7'h00, sda_in};
      ack_reg <= 1'b0;
    end else if (bit_cnt_reg == adcs_pkg::LAST_BIT) begin
      bit_cnt_reg <= adcs_pkg::ACK_SLOT;
      shift_reg <= byte_w;
      ack_reg <= 1'b0;
      unique case (link_st_reg)
        adcs_pkg::L_ADDR: begin
          if (byte_w == adcs_pkg::GC_ADDR_BYTE) begin
            ack_reg <= 1'b1;
            link_st_reg <= adcs_pkg::L_GC;
          end else if (byte_w[7:3] == adcs_pkg::HS_CODE_TOP) begin
            hs_tgl_reg <= ~hs_ack_reg;
            link_st_reg <= adcs_pkg::L_IGN;
          end else if (addr_valid && byte_w[7:1] == dev_addr) begin
            ack_reg <= 1'b1;
            byte_idx_reg <= 2'h0;
            link_st_reg <= byte_w[0] ? adcs_pkg::L_RD : adcs_pkg::L_WR;
          end else begin
            link_st_reg <= adcs_pkg::L_IGN;
          end
        end
        adcs_pkg::L_WR: begin
          if (byte_idx_reg == 2'h0) begin
            ack_reg <= 1'b1;
            wr_data_reg <= byte_w;
            evt_tgl_reg.cfg_write <= ~evt_tgl_reg.cfg_write;
            byte_idx_reg <= 2'h1;
          end
        end
        adcs_pkg::L_GC: begin
          if (byte_w == adcs_pkg::GC_CMD_LATCH) begin
            ack_reg <= 1'b1;
            evt_tgl_reg.gc_latch <= ~evt_tgl_reg.gc_latch;
          end else if (byte_w == adcs_pkg::GC_CMD_RESET) begin
            ack_reg <= 1'b1;
            evt_tgl_reg.gc_reset <= ~evt_tgl_reg.gc_reset;
          end
          link_st_reg <= adcs_pkg::L_IGN;
        end
        default: begin
        end
      endcase
    end else if (bit_cnt_reg == adcs_pkg::ACK_SLOT) begin
      bit_cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      if (link_st_reg == adcs_pkg::L_RD) begin
        if (ack_reg) begin
          tx_reg <= read_byte(2'h0, shadow_result_reg, shadow_cfg_reg);
        end else begin
          if (byte_idx_reg == adcs_pkg::RD_IDX_CFG) begin
            evt_tgl_reg.cfg_read <= ~evt_tgl_reg.cfg_read;
          end
          if (sda_in) begin
            link_st_reg <= adcs_pkg::L_IGN;
          end
          if (byte_idx_reg != adcs_pkg::RD_IDX_FILL) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
          end
          tx_reg <= read_byte(byte_idx_reg == adcs_pkg::RD_IDX_FILL ?
            adcs_pkg::RD_IDX_FILL : byte_idx_reg + 2'h1,
            shadow_result_reg, shadow_cfg_reg);
        end
      end
    end else begin
      shift_reg <= byte_w;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line drive, changed on clock fall only

  always_ff @(negedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_reg <= 1'b0;
    end else if (bit_cnt_reg == adcs_pkg::ACK_SLOT) begin
      sda_oe_reg <= ack_reg;
    end else if (link_st_reg == adcs_pkg::L_RD) begin
      sda_oe_reg <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {addr_sel_pin_high, addr_sel_pin_low};
      pin_s2_reg <= pin_s1_reg;
      busy_s1_reg <= link_busy;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      evt_s1_reg <= '0;
      evt_s2_reg <= '0;
      evt_s3_reg <= '0;
    end else begin
      evt_s1_reg <= evt_tgl_reg;
      evt_s2_reg <= evt_s1_reg;
      evt_s3_reg <= evt_s2_reg;
    end
  end

  assign evt_pulse = evt_s2_reg ^ evt_s3_reg;
  assign int_rst = evt_pulse.gc_reset;
  assign wr_cfg = wr_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address pin latch

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      startup_cnt_reg <= 2'h0;
    end else if (startup_cnt_reg != 2'h3) begin
      startup_cnt_reg <= startup_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_pins_reg <= 4'h0;
    end else if (startup_cnt_reg == adcs_pkg::PIN_SETTLE ||
        evt_pulse.gc_latch || evt_pulse.gc_reset) begin
      addr_pins_reg <= {pin_level(pin_s2_reg[3:2]),
        pin_level(pin_s2_reg[1:0])};
    end
  end

  assign addr_map = map_addr(addr_pins_reg);
  assign addr_valid = addr_map[3];
  assign dev_addr = {adcs_pkg::ADDR_BASE, addr_map[2:0]};

  ////////////////////////////////////////////////////////////////////////////
  // configuration and ready flag

  assign start_accept = evt_pulse.cfg_write && wr_cfg.single &&
    wr_cfg.ready && seq_reg == adcs_pkg::S_IDLE;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= adcs_pkg::CFG_DEFAULT;
    end else if (int_rst) begin
      cfg_reg <= adcs_pkg::CFG_DEFAULT;
    end else begin
      if (evt_pulse.cfg_write) begin
        cfg_reg.mux <= wr_cfg.mux;
        cfg_reg.single <= wr_cfg.single;
        cfg_reg.rate <= wr_cfg.rate;
        cfg_reg.gain <= wr_cfg.gain;
      end
      if (conv_done) begin
        cfg_reg.ready <= 1'b0;
      end else if (evt_pulse.cfg_read || start_accept) begin
        cfg_reg.ready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  assign conv_done = seq_reg == adcs_pkg::S_CONV && conv_cnt_reg == CONV_LAST;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_reg <= adcs_pkg::S_CONV;
      conv_cnt_reg <= 16'h0000;
    end else if (int_rst) begin
      seq_reg <= adcs_pkg::S_CONV;
      conv_cnt_reg <= 16'h0000;
    end else begin
      unique case (seq_reg)
        adcs_pkg::S_IDLE: begin
          conv_cnt_reg <= 16'h0000;
          if (start_accept || !cfg_reg.single) begin
            seq_reg <= adcs_pkg::S_CONV;
          end
        end
        adcs_pkg::S_CONV: begin
          if (conv_cnt_reg == CONV_LAST) begin
            conv_cnt_reg <= 16'h0000;
            if (cfg_reg.single) begin
              seq_reg <= adcs_pkg::S_IDLE;
            end
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  assign core_power_on = seq_reg == adcs_pkg::S_CONV;
  assign core_mux = cfg_reg.mux;
  assign core_rate = cfg_reg.rate;
  assign core_gain = cfg_reg.gain;

  ////////////////////////////////////////////////////////////////////////////
  // output register and frozen copy for the link

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_reg <= adcs_pkg::RESULT_DEFAULT;
    end else if (int_rst) begin
      result_reg <= adcs_pkg::RESULT_DEFAULT;
    end else if (conv_done) begin
      result_reg <= core_result;
    end
  end

  // copy held still while the bus is busy, so the link reads stable words
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shadow_result_reg <= adcs_pkg::RESULT_DEFAULT;
      shadow_cfg_reg <= adcs_pkg::CFG_DEFAULT;
    end else if (!busy_s2_reg) begin
      shadow_result_reg <= result_reg;
      shadow_cfg_reg <= cfg_reg;
    end
  end

endmodule // adcs_slave

// *** adcs_checker.sv ***
// assertions on the converter bus slave ports
// assumes bind onto adcs_slave; all sampled on clock
`timescale 1ns/1ns
module adcs_checker #(
  parameter int CONV_CYCLES = 20
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic core_power_on,
  input wire logic [1:0] core_mux,
  input wire logic [1:0] core_rate,
  input wire logic [1:0] core_gain,
  input wire logic hs_mode_active
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  int run_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) run_reg <= 0;
    else if (core_power_on) run_reg <= run_reg + 1;
    else run_reg <= 0;
  end
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  sequence s_stop_seen;
    scl_clk && sda_in && !$past(sda_in);
  endsequence
  a_drain_only: assert property (sda_out == 1'b0)
    else $error("data output driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("data pull changed with clock high");
  a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*3])
    else $error("data pull too short");
  a_idle_released: assert property (s_stop_seen |-> !sda_oe [*3])
    else $error("data pulled after stop");
  a_reset_cfg: assert property ($rose(resetn) |-> core_rate == 2'h3
    && core_mux == 2'h0 && core_gain == 2'h0 && core_power_on)
    else $error("configuration not default after reset");
  a_conv_length: assert property ($fell(core_power_on)
    |-> run_reg >= CONV_CYCLES)
    else $error("conversion ended early");
  a_hs_no_ack: assert property ($rose(hs_mode_active) |-> s_quiet)
    else $error("master code acknowledged");
  a_hs_ends_stop: assert property ($fell(hs_mode_active)
    |-> scl_clk && sda_in)
    else $error("fast mode left outside stop");
endmodule // adcs_checker
bind adcs_slave adcs_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clock(clock), .resetn(resetn), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .core_power_on(core_power_on),
  .core_mux(core_mux), .core_rate(core_rate), .core_gain(core_gain),
  .hs_mode_active(hs_mode_active));

// *** adcs_master.sv ***
// bus master model: bit-banged clock and data pull
// assumes the bench resolves the open-drain data wire
`timescale 1ns/1ns
module adcs_master (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  localparam int HALF = 16;
  logic r;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic start();
    if ($time % 2 != 0) #1;
    if (!scl) begin
      #2 pull = 1'b0;
      #14 scl = 1'b1;
      #HALF;
    end
    pull = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic s);
    #2 pull = !b;
    #14 scl = 1'b1;
    #8 s = sda;
    #8 scl = 1'b0;
  endtask
  task automatic stop();
    #2 pull = 1'b1;
    #14 scl = 1'b1;
    #HALF pull = 1'b0;
    #HALF;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // adcs_master

// *** tb.sv ***
// self-checking bench of the converter bus slave
// assumes adcs_master on the bus and a core result set by the bench
`timescale 1ns/1ns
module tb;
  localparam int CONV = 200;
  localparam logic [7:0] TAB [10] = '{8'h80, 8'h91, 8'h8a, 8'ha4,
    8'hb5, 8'hae, 8'hc3, 8'hcf, 8'h57, 8'h80};
  logic clock = 1'b0;
  logic resetn = 1'b1;
  adcs_pkg::adcs_pin_t pin_lo = 2'h0;
  adcs_pkg::adcs_pin_t pin_hi = 2'h0;
  logic [15:0] res = 16'h5a3c;
  logic sda, sda_oe, scl, pull, pwr, hs, ack;
  logic [1:0] mux, rate, gain;
  logic [7:0] st, d;
  int n_mismatch = 0;
  int tests_run = 0;
  assign sda = !(pull || sda_oe);
  assign st = {pwr, mux, rate, gain, hs};
  always #5 clock = !clock;
  adcs_slave #(.CONV_CYCLES(CONV)) uut (.clock(clock), .resetn(resetn),
    .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .addr_sel_pin_low(pin_lo), .addr_sel_pin_high(pin_hi),
    .core_result(res), .core_power_on(pwr), .core_mux(mux),
    .core_rate(rate), .core_gain(gain), .hs_mode_active(hs));
  adcs_master m (.scl(scl), .pull(pull), .sda(sda));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    m.start();
    m.wbyte(a, ack);
    chk({7'h0, ack}, 8'h01);
    m.wbyte(b, ack);
    chk({7'h0, ack}, 8'h01);
  endtask
  task automatic rd(input int n, input logic [31:0] exp);
    m.start();
    m.wbyte(8'h91, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk(d, i < 4 ? exp[31 - 8 * i -: 8] : 8'hff);
    end
    m.stop();
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    m.start();
    m.wbyte({a, 1'b0}, ack);
    chk({7'h0, ack}, {7'h0, e});
    m.stop();
  endtask
  ////////////////////////////////////////
  task automatic t_power_up();
    int gap;
    gap = 0;
    chk(st, 8'h98);
    repeat (3 * CONV) @(posedge clock) if (pwr !== 1'b1) gap++;
    chk(8'(gap), 8'h00);
    rd(5, 32'h5a3c0cff);
  endtask
  task automatic t_single();
    wr(8'h90, 8'h3b);
    m.wbyte(8'hbb, ack);
    chk({7'h0, ack}, 8'h00);
    m.stop();
    repeat (CONV + 10) @(posedge clock);
    chk(st, 8'h36);
    res <= 16'h1234;
    rd(3, 32'h5a3c3b00);
    rd(3, 32'h5a3cbb00);
    wr(8'h90, 8'hbb);
    m.stop();
    repeat (4) @(posedge clock);
    chk(st, 8'hb6);
    wr(8'h90, 8'hbb);
    m.stop();
    repeat (CONV) @(posedge clock);
    chk(st, 8'h36);
    rd(3, 32'h12343b00);
  endtask
  task automatic t_addr();
    foreach (TAB[i]) begin
      @(posedge clock);
      pin_hi <= TAB[i][6:5];
      pin_lo <= TAB[i][4:3];
      repeat (4) @(posedge clock);
      wr(8'h00, 8'h04);
      m.stop();
      probe({4'h9, TAB[i][2:0]}, TAB[i][7]);
      probe({4'h9, TAB[i][2:0] ^ 3'h1}, 1'b0);
    end
    chk(st, 8'h36);
  endtask
  task automatic t_gc_reset();
    m.start();
    m.wbyte(8'h00, ack);
    chk({7'h0, ack}, 8'h01);
    m.wbyte(8'h05, ack);
    chk({7'h0, ack}, 8'h00);
    m.stop();
    wr(8'h00, 8'h06);
    m.stop();
    repeat (4) @(posedge clock);
    chk(st, 8'h98);
    rd(3, 32'h00008c00);
  endtask
  task automatic t_hs();
    m.start();
    m.wbyte(8'h0b, ack);
    chk({ack, 6'h0, hs}, 8'h01);
    m.start();
    m.wbyte(8'h90, ack);
    chk({ack, 6'h0, hs}, 8'h81);
    m.stop();
    repeat (4) @(posedge clock);
    chk({7'h0, hs}, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (8) @(posedge clock);
    t_power_up();
    t_single();
    t_addr();
    t_gc_reset();
    t_hs();
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // tb
